// ==== hdl/flash_cfg_dev.sv ====
// device end: second volatile configuration register and read latency logic
`timescale 1ns/1ps
module flash_cfg_dev #(
  parameter logic [7:0] NV_CFG_TWO = cfg_two_pkg::CFG_TWO_NV_DEFAULT,
  parameter logic [7:0] NV_CFG_ONE = cfg_two_pkg::CFG_ONE_NV_DEFAULT
) (
  // system
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // link
  flash_link_if.dev       link,
  // user side status, ref_clk domain
  output logic [7:0]      cfg_two_out,
  output logic            quad_en_out,
  output logic            hw_reset_req
);

  // ----------------------------------------------------------------
  // link-side state
  // ----------------------------------------------------------------
  typedef enum {ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA_IN, ST_DATA_OUT, ST_IDLE} st_e;

  st_e        st_ff;
  logic [7:0] cmd_ff;
  logic [7:0] sh_ff;
  logic [5:0] cnt_ff;
  logic [31:0] addr_ff;
  logic [7:0] cfg_two_ff;
  logic [7:0] cfg_one_ff;
  logic [7:0] dout_ff;
  logic       drive_ff;
  logic       sw_rst_ff;
  logic       qpi;
  logic [7:0] nxt_sh;
  logic [5:0] beat_cnt;
  logic       frame_rst;

  assign qpi      = cfg_two_ff[cfg_two_pkg::FOUR_LINE_BIT];
  assign nxt_sh   = qpi ? {sh_ff[3:0], link.dq} : {sh_ff[6:0], link.dq[0]};
  // beats per byte on the wires
  assign beat_cnt = qpi ? 6'h02 : 6'h08;

  // resets that reload from the non-volatile copy
  assign frame_rst = rst | sw_rst_ff;

  // ----------------------------------------------------------------
  // hardware reset pin on line three, sampled on ref_clk
  // ----------------------------------------------------------------
  logic [1:0] cs_sync_ff;
  logic [1:0] d3_sync_ff;
  logic       pin_rst;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_sync_ff <= 2'h3;
      d3_sync_ff <= 2'h3;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
      d3_sync_ff <= {d3_sync_ff[0], link.dq[3]};
    end
  end

  // cfg bits are quasi-static here: changed only within a frame
  logic [1:0] rp_sync_ff;
  logic [1:0] qe_sync_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rp_sync_ff <= 2'h0;
      qe_sync_ff <= 2'h0;
    end else begin
      rp_sync_ff <= {rp_sync_ff[0], cfg_two_ff[cfg_two_pkg::RESET_PIN_BIT]};
      qe_sync_ff <= {qe_sync_ff[0], cfg_one_ff[cfg_two_pkg::QUAD_EN_BIT]};
    end
  end

  assign pin_rst = rp_sync_ff[1] & ~d3_sync_ff[1]
                 & (cs_sync_ff[1] | ~qe_sync_ff[1]);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hw_reset_req <= 1'b0;
    end else begin
      hw_reset_req <= pin_rst;
    end
  end

  // reset request crosses back to sck via a two-flop level
  logic [1:0] hr_sync_ff;
  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      hr_sync_ff <= 2'h0;
    end else begin
      hr_sync_ff <= {hr_sync_ff[0], hw_reset_req};
    end
  end

  // ----------------------------------------------------------------
  // command sequencer on sck; frame ends on cs_n high
  // ----------------------------------------------------------------
  logic [3:0] dummy_need;
  logic [3:0] mode_need;
  logic       var_lat;
  logic       has_addr;
  logic [5:0] addr_beats;

  always_comb begin
    var_lat    = 1'b0;
    has_addr   = 1'b1;
    mode_need  = cfg_two_pkg::MODE_CYC_SINGLE;
    dummy_need = 4'h0;
    case (cmd_ff)
      cfg_two_pkg::PLAIN_READ_CMD:       dummy_need = 4'h0;
      cfg_two_pkg::READ_PARAM_TABLE_CMD: dummy_need = cfg_two_pkg::PARAM_TABLE_DUMMY;
      cfg_two_pkg::FAST_READ_CMD,
      cfg_two_pkg::READ_ANY_REG_CMD:     var_lat = 1'b1;
      cfg_two_pkg::DUAL_READ_CMD: begin
        var_lat   = 1'b1;
        mode_need = cfg_two_pkg::MODE_CYC_DUAL;
      end
      cfg_two_pkg::QUAD_READ_CMD: begin
        var_lat   = 1'b1;
        mode_need = cfg_two_pkg::MODE_CYC_QUAD;
      end
      cfg_two_pkg::DDR_QUAD_READ_CMD: begin
        var_lat   = 1'b1;
        mode_need = cfg_two_pkg::MODE_CYC_DDR;
      end
      cfg_two_pkg::WRITE_ANY_REG_CMD:    dummy_need = 4'h0;
      default:                           has_addr = 1'b0;
    endcase
    if (var_lat) begin
      dummy_need = cfg_two_ff[cfg_two_pkg::DUMMY_MSB:0];
    end
    // register access commands carry address bytes per bit 7
    addr_beats = cfg_two_ff[cfg_two_pkg::ADDR_WIDTH_BIT]
               ? (qpi ? 6'h08 : 6'h20) : (qpi ? 6'h06 : 6'h18);
  end

  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      st_ff  <= ST_CMD;
      cnt_ff <= 6'h00;
      sh_ff  <= 8'h00;
    end else begin
      sh_ff <= nxt_sh;
      case (st_ff)
        ST_CMD: begin
          if (cnt_ff == beat_cnt - 6'h01) begin
            cnt_ff <= 6'h00;
            st_ff  <= ST_ADDR;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_ADDR: begin
          if (!has_addr) begin
            st_ff <= ST_IDLE;
          end else if (cnt_ff == addr_beats - 6'h01) begin
            cnt_ff <= 6'h00;
            if (cmd_ff == cfg_two_pkg::WRITE_ANY_REG_CMD) begin
              st_ff <= ST_DATA_IN;
            end else if (mode_need != 4'h0) begin
              st_ff <= ST_MODE;
            end else if (dummy_need != 4'h0) begin
              st_ff <= ST_DUMMY;
            end else begin
              st_ff <= ST_DATA_OUT;
            end
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_MODE: begin
          if (cnt_ff == {2'h0, mode_need} - 6'h01) begin
            cnt_ff <= 6'h00;
            st_ff  <= (dummy_need != 4'h0) ? ST_DUMMY : ST_DATA_OUT;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_DUMMY: begin
          if (cnt_ff == {2'h0, dummy_need} - 6'h01) begin
            cnt_ff <= 6'h00;
            st_ff  <= ST_DATA_OUT;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_DATA_IN: begin
          if (cnt_ff == beat_cnt - 6'h01) begin
            cnt_ff <= 6'h00;
            st_ff  <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 6'h01;
          end
        end
        ST_DATA_OUT: cnt_ff <= (cnt_ff == beat_cnt - 6'h01) ? 6'h00 : cnt_ff + 6'h01;
        ST_IDLE:     cnt_ff <= cnt_ff;
        default:     st_ff  <= ST_IDLE;
      endcase
    end
  end

  // capture command and address bytes
  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      cmd_ff  <= 8'h00;
      addr_ff <= 32'h0;
    end else if (!link.cs_n) begin
      if (st_ff == ST_CMD && cnt_ff == beat_cnt - 6'h01) begin
        cmd_ff <= nxt_sh;
      end
      if (st_ff == ST_ADDR) begin
        addr_ff <= qpi ? {addr_ff[27:0], link.dq} : {addr_ff[30:0], link.dq[0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic wr_hit;
  logic wide_hit;
  logic [31:0] eff_addr;

  assign eff_addr = cfg_two_ff[cfg_two_pkg::ADDR_WIDTH_BIT] ? addr_ff : {8'h0, addr_ff[23:0]};
  assign wr_hit   = !link.cs_n && st_ff == ST_DATA_IN && cnt_ff == beat_cnt - 6'h01
                  && cmd_ff == cfg_two_pkg::WRITE_ANY_REG_CMD;
  assign wide_hit = !link.cs_n && st_ff == ST_CMD && cnt_ff == beat_cnt - 6'h01
                  && nxt_sh == cfg_two_pkg::ENTER_WIDE_ADDR_CMD;

  // line-three reset reloads the boot values on the third sck edge after the request
  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      sw_rst_ff <= 1'b0;
    end else begin
      sw_rst_ff <= hr_sync_ff[1];
    end
  end

  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      cfg_two_ff <= NV_CFG_TWO & cfg_two_pkg::CFG_TWO_WMASK;
      cfg_one_ff <= NV_CFG_ONE;
    end else if (wr_hit && eff_addr == cfg_two_pkg::CFG_TWO_ADDR) begin
      cfg_two_ff <= nxt_sh & cfg_two_pkg::CFG_TWO_WMASK;
      if (nxt_sh[cfg_two_pkg::FOUR_LINE_BIT]) begin
        cfg_one_ff[cfg_two_pkg::QUAD_EN_BIT] <= 1'b1;
      end
    end else if (wr_hit && eff_addr == cfg_two_pkg::CFG_ONE_ADDR) begin
      cfg_one_ff <= nxt_sh;
    end else if (wide_hit) begin
      cfg_two_ff[cfg_two_pkg::ADDR_WIDTH_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read data out on falling sck
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  assign rd_byte = (eff_addr == cfg_two_pkg::CFG_TWO_ADDR) ? cfg_two_ff
                 : (eff_addr == cfg_two_pkg::CFG_ONE_ADDR) ? cfg_one_ff : 8'h00;

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      dout_ff <= 8'h00;
    end else if (st_ff == ST_DATA_OUT && cnt_ff == 6'h00) begin
      dout_ff <= rd_byte;
    end else begin
      dout_ff <= qpi ? {dout_ff[3:0], 4'h0} : {dout_ff[6:0], 1'b0};
    end
  end

  // drive from a falling edge only, once the host has let go of the lines
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= st_ff == ST_DATA_OUT && cmd_ff == cfg_two_pkg::READ_ANY_REG_CMD;
    end
  end
  assign link.dev_dq_o    = (cnt_ff == 6'h00) ? (qpi ? rd_byte[7:4] : {2'h0, rd_byte[7], 1'b0})
                          : (qpi ? dout_ff[7:4] : {2'h0, dout_ff[7], 1'b0});
  assign link.dev_dq_oe_n = drive_ff ? (qpi ? 4'h0 : 4'hD) : 4'hF;

  // ----------------------------------------------------------------
  // status to ref_clk domain, taken while the link is deselected
  // ----------------------------------------------------------------
  // the word only changes inside a frame, so a synced high cs_n marks it stable
  logic [8:0] status_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_ff <= {NV_CFG_ONE[cfg_two_pkg::QUAD_EN_BIT],
                    NV_CFG_TWO & cfg_two_pkg::CFG_TWO_WMASK};
    end else if (cs_sync_ff[1]) begin
      status_ff <= {cfg_one_ff[cfg_two_pkg::QUAD_EN_BIT], cfg_two_ff};
    end
  end
  assign cfg_two_out = status_ff[7:0];
  assign quad_en_out = status_ff[8];

endmodule // flash_cfg_dev

// ==== inc/cfg_two_pkg.sv ====
// package: constants for the second volatile configuration register link
package cfg_two_pkg;
  // command codes
  localparam logic [7:0] READ_ANY_REG_CMD     = 8'h65;
  localparam logic [7:0] WRITE_ANY_REG_CMD    = 8'h71;
  localparam logic [7:0] ENTER_WIDE_ADDR_CMD  = 8'hB7;
  localparam logic [7:0] READ_PARAM_TABLE_CMD = 8'h5A;
  localparam logic [7:0] PLAIN_READ_CMD       = 8'h03;
  localparam logic [7:0] FAST_READ_CMD        = 8'h0B;
  localparam logic [7:0] DUAL_READ_CMD        = 8'hBB;
  localparam logic [7:0] QUAD_READ_CMD        = 8'hEB;
  localparam logic [7:0] DDR_QUAD_READ_CMD    = 8'hED;
  // register addresses in the device register space
  localparam logic [31:0] CFG_TWO_ADDR = 32'h0080_0003;
  localparam logic [31:0] CFG_ONE_ADDR = 32'h0080_0002;
  // field positions
  localparam int ADDR_WIDTH_BIT  = 7;
  localparam int FOUR_LINE_BIT   = 6;
  localparam int RESET_PIN_BIT   = 5;
  localparam int RESERVED_BIT    = 4;
  localparam int DUMMY_MSB       = 3;
  localparam int QUAD_EN_BIT     = 1;
  localparam logic [7:0] CFG_TWO_WMASK = 8'hEF;
  // boot values of the non-volatile copy
  localparam logic [7:0] CFG_TWO_NV_DEFAULT = 8'h08;
  localparam logic [7:0] CFG_ONE_NV_DEFAULT = 8'h00;
  // fixed latencies and mode cycles
  localparam logic [3:0] PARAM_TABLE_DUMMY = 4'h8;
  localparam logic [3:0] MODE_CYC_SINGLE   = 4'h0;
  localparam logic [3:0] MODE_CYC_DUAL     = 4'h4;
  localparam logic [3:0] MODE_CYC_QUAD     = 4'h2;
  localparam logic [3:0] MODE_CYC_DDR      = 4'h1;
  // host clock limits in MHz, then the DDR quad dummy cycle range
  localparam int MAX_SDR_MHZ     = 133;
  localparam int MAX_DDR_MHZ     = 80;
  localparam int MAX_DDR_QPI_MHZ = 68;
  localparam logic [3:0] DDR_QPI_MIN_DUMMY = 4'h1;
  localparam logic [3:0] DDR_QPI_MAX_DUMMY = 4'h5;
endpackage

// ==== inc/flash_link_if.sv ====
// interface: serial flash link between host and device
`timescale 1ns/1ps
interface flash_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe_n;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe_n;
  logic [3:0] dq;
  assign dq = (~host_dq_oe_n & host_dq_o) | (~dev_dq_oe_n & dev_dq_o)
            | (host_dq_oe_n & dev_dq_oe_n);
  modport host (output sck, output cs_n, output host_dq_o, output host_dq_oe_n, input dq);
  modport dev  (input sck, input cs_n, output dev_dq_o, output dev_dq_oe_n, input dq);
endinterface

// ==== hdl/flash_cfg_host.sv ====
// host end: issues register read, register write and wide-address commands
`timescale 1ns/1ps
module flash_cfg_host #(
  parameter int CLK_DIV = 2
) (
  // system
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link
  flash_link_if.host       link,
  // user command port
  input  wire logic        req,
  input  wire logic [1:0]  op,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        four_byte,
  input  wire logic        four_line,
  input  wire logic [3:0]  dummy,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata
);
  // op 0 read any register, 1 write any register, 2 enter wide address
  typedef enum {H_IDLE, H_RUN, H_END} hst_e;
  hst_e        st_ff;
  logic [7:0]  div_ff;
  logic        sck_ff;
  logic [7:0]  bit_ff;
  logic [7:0]  total_ff;
  logic [63:0] sh_ff;
  logic [7:0]  rd_ff;
  logic        q_ff;
  logic        done_ff;
  logic [1:0]  op_ff;

  // ----------------------------------------------------------------
  // frame length in sck beats; sck is a divided ref_clk
  // ----------------------------------------------------------------
  logic [7:0] nxt_total;
  logic [7:0] ab;
  logic [7:0] cmd_code;
  logic [7:0] wbyte;
  always_comb begin
    ab = four_byte ? 8'd32 : 8'd24;
    cmd_code = (op == 2'h0) ? cfg_two_pkg::READ_ANY_REG_CMD
             : (op == 2'h1) ? cfg_two_pkg::WRITE_ANY_REG_CMD : cfg_two_pkg::ENTER_WIDE_ADDR_CMD;
    wbyte = (op == 2'h1) ? wdata : 8'h00;
    case (op)
      2'h0:    nxt_total = 8'd8 + ab + {4'h0, dummy} + 8'd8;
      2'h1:    nxt_total = 8'd8 + ab + 8'd8;
      default: nxt_total = 8'd8;
    endcase
    if (four_line) begin
      nxt_total = (op == 2'h0) ? 8'd2 + (ab >> 2) + {4'h0, dummy} + 8'd2
                : (op == 2'h1) ? 8'd2 + (ab >> 2) + 8'd2 : 8'd2;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff    <= H_IDLE;
      div_ff   <= 8'h00;
      sck_ff   <= 1'b0;
      bit_ff   <= 8'h00;
      total_ff <= 8'h00;
      sh_ff    <= 64'h0;
      rd_ff    <= 8'h00;
      q_ff     <= 1'b0;
      done_ff  <= 1'b0;
      op_ff    <= 2'h0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        H_IDLE: begin
          if (req) begin
            st_ff    <= H_RUN;
            total_ff <= nxt_total;
            q_ff     <= four_line;
            op_ff    <= op;
            bit_ff   <= 8'h00;
            div_ff   <= 8'h00;
            // data byte follows the last address byte directly
            sh_ff    <= four_byte ? {cmd_code, addr, wbyte, 16'h0000}
                                  : {cmd_code, addr[23:0], wbyte, 24'h000000};
          end
        end
        H_RUN: begin
          if (div_ff == 8'(CLK_DIV - 1)) begin
            div_ff <= 8'h00;
            sck_ff <= ~sck_ff;
            if (sck_ff) begin
              // falling edge: shift next bits out
              sh_ff  <= q_ff ? {sh_ff[59:0], 4'h0} : {sh_ff[62:0], 1'b0};
              bit_ff <= bit_ff + 8'h01;
              if (bit_ff == total_ff - 8'h01) begin
                st_ff <= H_END;
              end
            end else begin
              rd_ff <= q_ff ? {rd_ff[3:0], link.dq} : {rd_ff[6:0], link.dq[1]};
            end
          end else begin
            div_ff <= div_ff + 8'h01;
          end
        end
        H_END: begin
          st_ff   <= H_IDLE;
          done_ff <= 1'b1;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  logic data_phase;
  assign data_phase = (op_ff == 2'h0) && (bit_ff >= total_ff - (q_ff ? 8'd2 : 8'd8));

  assign link.sck          = sck_ff;
  assign link.cs_n         = (st_ff != H_RUN);
  assign link.host_dq_o    = q_ff ? sh_ff[63:60] : {3'h0, sh_ff[63]};
  assign link.host_dq_oe_n = (st_ff != H_RUN || data_phase) ? 4'hF : (q_ff ? 4'h0 : 4'hE);
  assign busy              = (st_ff != H_IDLE);
  assign done              = done_ff;
  assign rdata             = rd_ff;

endmodule // flash_cfg_host

// ==== tb/flash_cfg_checker.sv ====
// checker: link-level properties of the serial flash configuration link
`timescale 1ns/1ps
module flash_cfg_checker #(
  parameter int CLK_DIV = 2
) (
  // system
  input wire logic       ref_clk,
  input wire logic       rst,
  // link
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic [3:0] host_dq_o,
  input wire logic [3:0] host_dq_oe_n,
  input wire logic [3:0] dev_dq_o,
  input wire logic [3:0] dev_dq_oe_n,
  input wire logic [3:0] dq
);
  localparam int FRAME_MAX = 600;

  logic       sck_ff;
  logic [7:0] hold_ff;
  logic [7:0] rise_ff;

  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) sck_ff <= 1'b0;
    else sck_ff <= sck;
  end

  // cycles since sck last changed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) hold_ff <= 8'h00;
    else if (sck != sck_ff) hold_ff <= 8'h00;
    else if (hold_ff != 8'hFF) hold_ff <= hold_ff + 8'h01;
  end

  // sck rising edges within the current frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rise_ff <= 8'h00;
    else if (cs_n) rise_ff <= 8'h00;
    else if (sck && !sck_ff && rise_ff != 8'hFF) rise_ff <= rise_ff + 8'h01;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_no_contention: assert property ((~host_dq_oe_n & ~dev_dq_oe_n) == 4'h0)
    else $error("host and device drive the same data line");
  a_dev_quiet_idle: assert property (cs_n [*3] |-> dev_dq_oe_n == 4'hF)
    else $error("device drives data lines while deselected");
  a_line3_idle_high: assert property (cs_n |-> dq[3])
    else $error("line three is low while deselected");
  a_sck_idle_low: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock runs outside a frame");
  a_sck_half_period: assert property (!cs_n && sck != sck_ff |-> hold_ff >= CLK_DIV - 1)
    else $error("serial clock half period too short");
  a_cs_fall_clean: assert property ($fell(cs_n) |-> !sck && !$past(sck))
    else $error("frame opens with serial clock high");
  a_frame_bounded: assert property ($fell(cs_n) |-> ##[1:FRAME_MAX] $rose(cs_n))
    else $error("frame does not close in time");
  a_frame_min_beats: assert property ($rose(cs_n) |-> rise_ff >= 8'h02)
    else $error("frame closed without a full instruction");
endmodule // flash_cfg_checker

// ==== tb/flash_volatile_config_two_bench.sv ====
// testbench: host and device ends joined over the serial flash link
`timescale 1ns/1ps
module flash_volatile_config_two_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] BOOT = cfg_two_pkg::CFG_TWO_NV_DEFAULT & cfg_two_pkg::CFG_TWO_WMASK;
  localparam logic [31:0] A2 = cfg_two_pkg::CFG_TWO_ADDR;
  logic        ref_clk;
  logic        rst;
  logic        req;
  logic [1:0]  op;
  logic [31:0] addr;
  logic [7:0]  wdata;
  logic        four_byte;
  logic        four_line;
  logic [3:0]  dummy;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic [7:0]  cfg_two_out;
  logic        quad_en_out;
  logic        hw_reset_req;
  int          fail_count;
  int          checks_done;

  flash_link_if flash_link_if_i ();

  flash_cfg_host #(.CLK_DIV(2)) flash_cfg_host_i (
    .ref_clk(ref_clk), .rst(rst), .link(flash_link_if_i.host), .req(req), .op(op),
    .addr(addr), .wdata(wdata), .four_byte(four_byte), .four_line(four_line),
    .dummy(dummy), .busy(busy), .done(done), .rdata(rdata));

  flash_cfg_dev flash_cfg_dev_i (
    .ref_clk(ref_clk), .rst(rst), .link(flash_link_if_i.dev), .cfg_two_out(cfg_two_out),
    .quad_en_out(quad_en_out), .hw_reset_req(hw_reset_req));

  flash_cfg_checker #(.CLK_DIV(2)) flash_cfg_checker_i (
    .ref_clk(ref_clk), .rst(rst), .sck(flash_link_if_i.sck), .cs_n(flash_link_if_i.cs_n),
    .host_dq_o(flash_link_if_i.host_dq_o), .host_dq_oe_n(flash_link_if_i.host_dq_oe_n),
    .dev_dq_o(flash_link_if_i.dev_dq_o), .dev_dq_oe_n(flash_link_if_i.dev_dq_oe_n),
    .dq(flash_link_if_i.dq));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one framed command; status outputs settle before return
  task automatic run_cmd(input logic [1:0] o, input logic [31:0] a, input logic [7:0] w);
    int n;
    op = o;
    addr = a;
    wdata = w;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      $display("ERROR at %0t: no completion seen", $time);
    end
    tick(4);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    run_cmd(2'h0, a, 8'h00);
    check(rdata, exp);
  endtask

  task automatic do_reset;
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(1);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #200000;
    fail_count++;
    test_done;
  end

  initial begin
    rst = 1'b1;
    req = 1'b0;
    op = 2'h0;
    addr = 32'h0000_0000;
    wdata = 8'h00;
    four_byte = 1'b0;
    four_line = 1'b0;
    dummy = BOOT[3:0];
    fail_count = 0;
    checks_done = 0;
    tick(4);
    rst = 1'b0;
    tick(1);
    check(cfg_two_out, BOOT);
    check({7'h00, quad_en_out}, {7'h00, cfg_two_pkg::CFG_ONE_NV_DEFAULT[1]});
    rd(A2, BOOT);
    run_cmd(2'h1, A2, 8'h13);
    check(cfg_two_out, 8'h03);
    dummy = 4'h3;
    rd(A2, 8'h03);
    // latency field at both ends of its range
    for (int i = 0; i < 2; i++) begin
      run_cmd(2'h1, A2, (i == 0) ? 8'h00 : 8'h0F);
      dummy = (i == 0) ? 4'h0 : 4'hF;
      rd(A2, {4'h0, dummy});
    end
    run_cmd(2'h2, 32'h0000_0000, 8'h00);
    check(cfg_two_out, 8'h8F);
    four_byte = 1'b1;
    rd(A2, 8'h8F);
    run_cmd(2'h1, A2, 8'hC5);
    check({7'h00, quad_en_out}, 8'h01);
    four_line = 1'b1;
    dummy = 4'h5;
    rd(A2, 8'hC5);
    run_cmd(2'h1, A2, 8'h25);
    check({7'h00, quad_en_out}, 8'h01);
    four_line = 1'b0;
    four_byte = 1'b0;
    rd(A2, 8'h25);
    rd(cfg_two_pkg::CFG_ONE_ADDR, cfg_two_pkg::CFG_ONE_NV_DEFAULT | 8'h02);
    check({7'h00, hw_reset_req}, 8'h00);
    do_reset;
    check(cfg_two_out, BOOT);
    check({7'h00, quad_en_out}, {7'h00, cfg_two_pkg::CFG_ONE_NV_DEFAULT[1]});
    dummy = BOOT[3:0];
    rd(A2, BOOT);
    test_done;
  end
endmodule // flash_volatile_config_two_bench
